// file: logic/com_port_glue.sv
// Notes on behaviour
// - second port interrupt routed by 3-bit select onto an irq line, only when enabled
// - second port base code picks one of ten bases, default 0001
// - auto direction in 485 mode: driver on while bytes are pending
// - manual direction in 485 mode: driver on when rts is 0
// - auto direction bits: bit 5 second port, bit 4 first, default off
// - disabled port: tx and rts off, no claim, cycles forwarded to isa
// - output enables at bits 1 and 0, default on, drive tx and rts
// - fast bit clear multiplies divisor by 16, set passes it unchanged
// - reserved bits ignore writes and read zero
// - each isa enable passes its line when 1, blocks when 0, default 0
// - low gate bits 7..0 map to lines 11,10,9,7,6,5,4,3
// - high gate bits 2..0 map to 15,14,12; bits 7..3 read zero
// - isa lines active high, passed straight through without capture
// - line standard bit: 0 rs232, 1 rs422/485; bit 0 first, bit 1 second
`timescale 1ns/100ps
`include "glue_regs.svh"

module com_port_glue (
    // clock and reset
    input  wire logic                  clk_sys_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    // register access
    input  wire glue_pkg::reg_req_s    reg_req_i,
    output logic [7:0]                 reg_rdata_o,
    output logic                       reg_rvalid_o,
    // uart io window decode
    input  wire logic [15:0]           io_addr_i,
    input  wire logic                  io_cycle_i,
    input  wire logic [3:0]            first_port_base_i,
    output logic [1:0]                 port_claim_o,
    output logic [1:0]                 isa_forward_o,
    // uart core side
    input  wire logic [1:0]            tx_data_i,
    input  wire logic [1:0]            tx_pending_i,
    input  wire logic [1:0]            rts_bit_i,
    input  wire logic [1:0][15:0]      divisor_i,
    output logic [1:0][19:0]           eff_divisor_o,
    output glue_pkg::port_pins_s [1:0] port_o,
    // interrupts
    input  wire logic                  second_port_irq_i,
    input  wire logic [15:0]           isa_irq_i,
    output logic [15:0]                serirq_lines_o
);
    import glue_pkg::*;

    logic [7:0]  com2_ctrl_q;
    logic [7:0]  port_mode_q;
    logic [7:0]  baud_mode_q;
    logic [7:0]  isa_low_q;
    logic [7:0]  isa_high_q;
    logic [7:0]  xcvr_mode_q;
    logic [7:0]  rdata_q;
    logic        rvalid_q;
    logic [1:0]  port_en;
    logic [1:0]  auto_dir;
    logic [1:0]  line_std;
    logic [3:0]  base_code [1:0];
    logic [15:0] gate_vec;
    logic [15:0] route_vec;
    port_pins_s [1:0] pins_q;
    logic [1:0][19:0] div_q;

    function automatic logic [3:0] route_irq(input logic [2:0] sel);
        case (sel)
            3'h0:    route_irq = 4'h3;
            3'h1:    route_irq = 4'h4;
            3'h2:    route_irq = 4'h5;
            3'h3:    route_irq = 4'hA;
            3'h4:    route_irq = 4'h6;
            3'h5:    route_irq = 4'h7;
            3'h6:    route_irq = 4'h9;
            default: route_irq = 4'hB;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [2:0] ofs, input logic [7:0] c2,
                                            input logic [7:0] pm, input logic [7:0] bm,
                                            input logic [7:0] il, input logic [7:0] ih,
                                            input logic [7:0] xm);
        case (ofs)
            `OFS_COM2_CTRL: reg_read = c2;
            `OFS_PORT_MODE: reg_read = pm;
            `OFS_BAUD_MODE: reg_read = bm;
            `OFS_ISA_LOW:   reg_read = il;
            `OFS_ISA_HIGH:  reg_read = ih;
            `OFS_XCVR_MODE: reg_read = xm;
            default:        reg_read = 8'h00;
        endcase
    endfunction

    assign port_en  = {port_mode_q[`BIT_OE_P2], port_mode_q[`BIT_OE_P1]};
    assign auto_dir = {port_mode_q[`BIT_ADC_P2], port_mode_q[`BIT_ADC_P1]};
    assign line_std = {xcvr_mode_q[`BIT_STD_P2], xcvr_mode_q[`BIT_STD_P1]};
    assign base_code[0] = first_port_base_i;
    assign base_code[1] = com2_ctrl_q[`POS_IO_BASE +: 4];

    // register writes; only writable bits are stored so reserved bits stay zero
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            com2_ctrl_q <= `RST_COM2_CTRL;
            port_mode_q <= `RST_PORT_MODE;
            baud_mode_q <= `RST_BAUD_MODE;
            isa_low_q   <= `RST_ISA_LOW;
            isa_high_q  <= `RST_ISA_HIGH;
            xcvr_mode_q <= `RST_XCVR_MODE;
        end else if (ce_i && reg_req_i.wr) begin
            case (reg_req_i.addr)
                `OFS_COM2_CTRL: com2_ctrl_q <= reg_req_i.wdata & `MSK_COM2_CTRL;
                `OFS_PORT_MODE: port_mode_q <= reg_req_i.wdata & `MSK_PORT_MODE;
                `OFS_BAUD_MODE: baud_mode_q <= reg_req_i.wdata & `MSK_BAUD_MODE;
                `OFS_ISA_LOW:   isa_low_q   <= reg_req_i.wdata & `MSK_ISA_LOW;
                `OFS_ISA_HIGH:  isa_high_q  <= reg_req_i.wdata & `MSK_ISA_HIGH;
                `OFS_XCVR_MODE: xcvr_mode_q <= reg_req_i.wdata & `MSK_XCVR_MODE;
                default: ;
            endcase
        end
    end

    // register reads, answered one cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (ce_i) begin
            rvalid_q <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                rdata_q <= reg_read(reg_req_i.addr, com2_ctrl_q, port_mode_q, baud_mode_q,
                                    isa_low_q, isa_high_q, xcvr_mode_q);
            end
        end
    end

    assign reg_rdata_o  = rdata_q;
    assign reg_rvalid_o = rvalid_q;

    // io window decode for each port
    port_window u_win1 (
        .io_addr_i   (io_addr_i),
        .io_cycle_i  (io_cycle_i),
        .base_code_i (base_code[0]),
        .enable_i    (port_en[0]),
        .claim_o     (port_claim_o[0]),
        .pass_isa_o  (isa_forward_o[0])
    );

    port_window u_win2 (
        .io_addr_i   (io_addr_i),
        .io_cycle_i  (io_cycle_i),
        .base_code_i (base_code[1]),
        .enable_i    (port_en[1]),
        .claim_o     (port_claim_o[1]),
        .pass_isa_o  (isa_forward_o[1])
    );

    // line driver control per port
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            pins_q <= '0;
        end else if (ce_i) begin
            for (int p = 0; p < 2; p++) begin
                pins_q[p].tx       <= port_en[p] & tx_data_i[p];
                pins_q[p].tx_oe    <= port_en[p];
                pins_q[p].rts      <= port_en[p] & rts_bit_i[p];
                pins_q[p].rts_oe   <= port_en[p];
                pins_q[p].line_std <= line_std[p];
                if (!port_en[p]) begin
                    pins_q[p].drv_en <= 1'b0;
                end else if (!line_std[p]) begin
                    pins_q[p].drv_en <= 1'b1;
                end else if (auto_dir[p]) begin
                    pins_q[p].drv_en <= tx_pending_i[p];
                end else begin
                    pins_q[p].drv_en <= !rts_bit_i[p];
                end
            end
        end
    end

    assign port_o = pins_q;

    // baud divisor scaling shared by both ports
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else if (ce_i) begin
            for (int p = 0; p < 2; p++) begin
                if (baud_mode_q[`BIT_FAST]) begin
                    div_q[p] <= {4'h0, divisor_i[p]};
                end else begin
                    div_q[p] <= {divisor_i[p], 4'h0};
                end
            end
        end
    end

    assign eff_divisor_o = div_q;

    // interrupt lines go straight through; no flip-flop sits in this path
    always_comb begin
        gate_vec     = 16'h0000;
        gate_vec[3]  = isa_low_q[0];
        gate_vec[4]  = isa_low_q[1];
        gate_vec[5]  = isa_low_q[2];
        gate_vec[6]  = isa_low_q[3];
        gate_vec[7]  = isa_low_q[4];
        gate_vec[9]  = isa_low_q[5];
        gate_vec[10] = isa_low_q[6];
        gate_vec[11] = isa_low_q[7];
        gate_vec[12] = isa_high_q[0];
        gate_vec[14] = isa_high_q[1];
        gate_vec[15] = isa_high_q[2];
        route_vec    = 16'h0000;
        if (com2_ctrl_q[`BIT_ROUTE_EN]) begin
            route_vec[route_irq(com2_ctrl_q[`POS_LINE_SEL +: 3])] = second_port_irq_i;
        end
    end

    assign serirq_lines_o = (isa_irq_i & gate_vec) | route_vec;

    property p_route;
        @(posedge clk_sys_i) disable iff (rst_i)
        (com2_ctrl_q[7] && second_port_irq_i) |->
            serirq_lines_o[route_irq(com2_ctrl_q[6:4])];
    endproperty
    a_route: assert property (p_route) else $error("routed irq line not raised");

    property p_defaults;
        @(posedge clk_sys_i) disable iff (rst_i)
        $past(rst_i) |-> (com2_ctrl_q == 8'h01) && (port_mode_q == 8'h03) &&
                         (isa_low_q == 8'h00) && (baud_mode_q == 8'h00);
    endproperty
    a_defaults: assert property (p_defaults) else $error("wrong reset value");

    property p_auto_dir;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !rst_i && port_en[1] && line_std[1] && auto_dir[1]) |=>
            (port_o[1].drv_en == $past(tx_pending_i[1]));
    endproperty
    a_auto_dir: assert property (p_auto_dir) else $error("auto direction wrong");

    property p_manual_dir;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !rst_i && port_en[0] && line_std[0] && !auto_dir[0]) |=>
            (port_o[0].drv_en == !$past(rts_bit_i[0]));
    endproperty
    a_manual_dir: assert property (p_manual_dir) else $error("manual direction wrong");

    property p_disabled;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !port_en[1]) ##1 !port_en[1] |->
            !port_o[1].tx_oe && !port_o[1].rts_oe && !port_o[1].drv_en && !port_claim_o[1];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled port still active");

    property p_enabled_claim;
        @(posedge clk_sys_i) disable iff (rst_i)
        (port_en[1] && io_cycle_i && base_code[1] == 4'h1 && io_addr_i[15:3] == 13'h005F)
            |-> port_claim_o[1] && !isa_forward_o[1];
    endproperty
    a_enabled_claim: assert property (p_enabled_claim) else $error("base not claimed");

    property p_scale;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !rst_i && !baud_mode_q[0]) |=>
            (eff_divisor_o[0] == {$past(divisor_i[0]), 4'h0});
    endproperty
    a_scale: assert property (p_scale) else $error("legacy divisor not scaled");

    property p_reserved;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && reg_req_i.rd && reg_req_i.addr == 3'h4) |=>
            reg_rvalid_o && reg_rdata_o[7:3] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

    property p_gate_block;
        @(posedge clk_sys_i) disable iff (rst_i)
        (!isa_high_q[2] && isa_irq_i[15]) |-> !serirq_lines_o[15];
    endproperty
    a_gate_block: assert property (p_gate_block) else $error("blocked isa line passed");

    property p_pass;
        @(posedge clk_sys_i) disable iff (rst_i)
        isa_low_q[7] |-> (serirq_lines_o[11] || !isa_irq_i[11]) &&
                         (isa_irq_i[11] || route_vec[11] || !serirq_lines_o[11]);
    endproperty
    a_pass: assert property (p_pass) else $error("isa line not passed through");

endmodule

// file: logic/glue_pkg.sv
package glue_pkg;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic tx;
        logic tx_oe;
        logic rts;
        logic rts_oe;
        logic drv_en;
        logic line_std;
    } port_pins_s;

endpackage

// file: logic/glue_regs.svh
`ifndef GLUE_REGS_SVH
`define GLUE_REGS_SVH

// register offsets inside the glue bank
`define OFS_COM2_CTRL   3'h0
`define OFS_PORT_MODE   3'h1
`define OFS_BAUD_MODE   3'h2
`define OFS_ISA_LOW     3'h3
`define OFS_ISA_HIGH    3'h4
`define OFS_XCVR_MODE   3'h5

// reset values
`define RST_COM2_CTRL   8'h01
`define RST_PORT_MODE   8'h03
`define RST_BAUD_MODE   8'h00
`define RST_ISA_LOW     8'h00
`define RST_ISA_HIGH    8'h00
`define RST_XCVR_MODE   8'h00

// writable bits of each register
`define MSK_COM2_CTRL   8'hFF
`define MSK_PORT_MODE   8'h33
`define MSK_BAUD_MODE   8'h01
`define MSK_ISA_LOW     8'hFF
`define MSK_ISA_HIGH    8'h07
`define MSK_XCVR_MODE   8'h03

// field positions
`define BIT_ROUTE_EN    7
`define POS_LINE_SEL    4
`define POS_IO_BASE     0
`define BIT_ADC_P2      5
`define BIT_ADC_P1      4
`define BIT_OE_P2       1
`define BIT_OE_P1       0
`define BIT_FAST        0
`define BIT_STD_P2      1
`define BIT_STD_P1      0

// divisor scaling in legacy mode: shift by four, times 16
`define DIV_SHIFT       4
// width of the address span claimed by each port (eight addresses)
`define SPAN_BITS       3

`endif

// file: logic/port_window.sv
`timescale 1ns/100ps
`include "glue_regs.svh"

module port_window (
    // io cycle
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_cycle_i,
    // port setup
    input  wire logic [3:0]  base_code_i,
    input  wire logic        enable_i,
    // decode result
    output logic             claim_o,
    output logic             pass_isa_o
);

    function automatic logic [15:0] base_addr(input logic [3:0] code);
        case (code)
            4'h0:    base_addr = 16'h03F8;
            4'h1:    base_addr = 16'h02F8;
            4'h2:    base_addr = 16'h03E8;
            4'h3:    base_addr = 16'h02E8;
            4'h4:    base_addr = 16'h0200;
            4'h5:    base_addr = 16'h0208;
            4'h6:    base_addr = 16'h0220;
            4'h7:    base_addr = 16'h0228;
            4'h8:    base_addr = 16'h0238;
            4'h9:    base_addr = 16'h0338;
            default: base_addr = 16'h0000;
        endcase
    endfunction

    logic [15:0] base;
    logic        valid_code;
    logic        in_range;

    // all bases are eight-aligned, so the span is a match on the upper bits
    assign base       = base_addr(base_code_i);
    assign valid_code = (base_code_i <= 4'h9);
    assign in_range   = io_cycle_i && valid_code &&
                        (io_addr_i[15:`SPAN_BITS] == base[15:`SPAN_BITS]);
    assign claim_o    = in_range && enable_i;
    assign pass_isa_o = in_range && !enable_i;

endmodule

// file: test/host_model.sv
`timescale 1ns/100ps

module host_model (
    // clock
    input  wire logic          clk_sys_i,
    // register request
    output glue_pkg::reg_req_s reg_req_o
);
    import glue_pkg::*;

    initial reg_req_o = '0;

    // one strobe cycle per access, then a quiet cycle; address and data turn over when released
    task automatic access(input logic rd, input logic wr, input logic [2:0] addr,
                          input logic [7:0] wdata);
        logic [7:0] d;
        d = (addr == 3'h4) ? (wdata & 8'h7F) : wdata;
        @(posedge clk_sys_i);
        reg_req_o <= '{rd: rd, wr: wr, addr: addr, wdata: d};
        @(posedge clk_sys_i);
        reg_req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~d};
    endtask
endmodule

// file: test/test_com_port_glue.sv
`timescale 1ns/100ps

module test_com_port_glue;
    import glue_pkg::*;

    logic              clk_sys_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              ce_i = 1'b1;
    reg_req_s          reg_req;
    logic [7:0]        reg_rdata_o;
    logic              reg_rvalid_o;
    logic [15:0]       io_addr = 16'h0000;
    logic              io_cycle = 1'b0;
    logic [3:0]        p1_base = 4'hF;
    logic [1:0]        port_claim_o;
    logic [1:0]        isa_forward_o;
    logic [1:0]        tx_data = 2'h0;
    logic [1:0]        tx_pending = 2'h0;
    logic [1:0]        rts_bit = 2'h0;
    logic [1:0][15:0]  divisor = '0;
    logic [1:0][19:0]  eff_divisor_o;
    port_pins_s [1:0]  port_o;
    logic              p2_irq = 1'b0;
    logic [15:0]       isa_irq = 16'h0000;
    logic [15:0]       serirq_lines_o;
    logic [7:0]        exp_q[$];
    int                errors = 0;
    int                total_checks = 0;
    int                cycles = 0;
    logic [15:0]       bases[10] = '{16'h3F8, 16'h2F8, 16'h3E8, 16'h2E8, 16'h200,
                                     16'h208, 16'h220, 16'h228, 16'h238, 16'h338};
    int                lo_map[8] = '{3, 4, 5, 6, 7, 9, 10, 11};
    int                hi_map[3] = '{12, 14, 15};
    int                sel_map[8] = '{3, 4, 5, 10, 6, 7, 9, 11};
    logic [7:0]        rst_v[8] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]        msk[8] = '{8'hFF, 8'h33, 8'h01, 8'hFF, 8'h07, 8'h03, 8'h00, 8'h00};
    logic [7:0]        d;
    logic [15:0]       e;
    logic              en;
    logic              std;
    logic              auto;
    logic              drv;
    logic [7:0]        exp_rd;

    host_model host (.clk_sys_i(clk_sys_i), .reg_req_o(reg_req));

    com_port_glue uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .reg_req_i(reg_req),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .io_addr_i(io_addr),
        .io_cycle_i(io_cycle), .first_port_base_i(p1_base), .port_claim_o(port_claim_o),
        .isa_forward_o(isa_forward_o), .tx_data_i(tx_data), .tx_pending_i(tx_pending),
        .rts_bit_i(rts_bit), .divisor_i(divisor), .eff_divisor_o(eff_divisor_o),
        .port_o(port_o), .second_port_irq_i(p2_irq), .isa_irq_i(isa_irq),
        .serirq_lines_o(serirq_lines_o));

    initial begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        host.access(1'b0, 1'b1, a, v);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] v);
        exp_q.push_back(v);
        host.access(1'b1, 1'b0, a, 8'h00);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // read results are matched against the oldest noted expectation
    always @(posedge clk_sys_i) begin
        if (reg_rvalid_o === 1'b1) begin
            exp_rd = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            chk({12'h000, reg_rdata_o}, {12'h000, exp_rd});
        end
    end

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            conclude();
        end
    end

    initial begin
        void'($urandom(32'h2283));
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) rd(a[2:0], rst_v[a]);
        for (int a = 0; a < 8; a++) begin
            d = 8'($urandom);
            wr(a[2:0], d);
            rd(a[2:0], d & msk[a]);
        end
        // frozen clock enable drops the write
        wr(3'h3, 8'h5A);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        wr(3'h3, 8'hA5);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        rd(3'h3, 8'h5A);
        // io window decode, ports enabled before any cycle
        wr(3'h1, 8'h03);
        @(posedge clk_sys_i);
        io_cycle <= 1'b1;
        for (int c = 0; c < 10; c++) begin
            wr(3'h0, {4'h0, c[3:0]});
            @(posedge clk_sys_i);
            p1_base <= 4'((c + 5) % 10);
            io_addr <= bases[c] + 16'($urandom % 8);
            tick(1);
            chk({18'h0, port_claim_o}, 20'h2);
            chk({18'h0, isa_forward_o}, 20'h0);
        end
        wr(3'h1, 8'h01);
        tick(1);
        chk({16'h0, port_claim_o, isa_forward_o}, 20'h2);
        wr(3'h0, 8'h0A);
        tick(1);
        chk({16'h0, port_claim_o, isa_forward_o}, 20'h0);
        // transmit pins and driver direction
        for (int k = 0; k < 8; k++) begin
            en = k[2];
            std = k[1];
            auto = k[0] & k[1];
            wr(3'h5, {6'h00, std, std});
            wr(3'h1, {2'b00, auto, auto, 2'b00, en, en});
            @(posedge clk_sys_i);
            tx_data <= 2'($urandom);
            tx_pending <= 2'($urandom);
            rts_bit <= 2'($urandom);
            tick(3);
            for (int p = 0; p < 2; p++) begin
                drv = !en ? 1'b0 : !std ? 1'b1 : auto ? tx_pending[p] : !rts_bit[p];
                chk({14'h0, port_o[p]}, {14'h0, en & tx_data[p], en, en & rts_bit[p], en,
                                         drv, std});
            end
        end
        // divisor scaling in both modes
        for (int f = 0; f < 2; f++) begin
            wr(3'h2, {7'h00, f[0]});
            @(posedge clk_sys_i);
            divisor <= {16'($urandom), 16'($urandom)};
            tick(3);
            for (int p = 0; p < 2; p++) begin
                chk(eff_divisor_o[p], f[0] ? {4'h0, divisor[p]} : {divisor[p], 4'h0});
            end
        end
        // isa line gating, passed straight through
        d = 8'($urandom) | 8'h80;
        wr(3'h3, d);
        wr(3'h4, 8'h05);
        for (int n = 0; n < 4; n++) begin
            @(posedge clk_sys_i);
            isa_irq <= 16'($urandom);
            #1;
            e = '0;
            for (int b = 0; b < 8; b++) if (d[b]) e[lo_map[b]] = isa_irq[lo_map[b]];
            for (int b = 0; b < 3; b += 2) e[hi_map[b]] = isa_irq[hi_map[b]];
            chk({4'h0, serirq_lines_o}, {4'h0, e});
        end
        // second port interrupt routing for every select code
        wr(3'h3, 8'h00);
        wr(3'h4, 8'h00);
        @(posedge clk_sys_i);
        p2_irq <= 1'b1;
        isa_irq <= 16'hFFFF;
        for (int s = 0; s < 8; s++) begin
            wr(3'h0, {1'b1, s[2:0], 4'h1});
            tick(1);
            chk({4'h0, serirq_lines_o}, {4'h0, 16'h0001 << sel_map[s]});
        end
        wr(3'h0, 8'h71);
        tick(1);
        chk({4'h0, serirq_lines_o}, 20'h0);
        // mid-run reset brings every register back to its default
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 8; a++) rd(a[2:0], rst_v[a]);
        tick(4);
        chk(20'(exp_q.size()), 20'h0);
        conclude();
    end
endmodule
